// [hdl/liu_regs.svh]
// Constants for the load instruction unit: field positions, opcodes, reset values
`ifndef LIU_REGS_SVH
`define LIU_REGS_SVH

// ==========================================================
// Instruction field positions
`define LIU_OPC_LSB 26
`define LIU_RS_LSB 21
`define LIU_RT_LSB 16
`define LIU_RD_LSB 11
`define LIU_FD_LSB 6
`define LIU_FUNC_LSB 0
`define LIU_IMM_LSB 0

// ==========================================================
// Major opcodes and function codes
`define LIU_OPC_SIGNED_HALF 6'h21
`define LIU_OPC_UNSIGNED_HALF 6'h25
`define LIU_OPC_LINKED_WORD 6'h30
`define LIU_OPC_UPPER_IMM 6'h0F
`define LIU_OPC_FP_EXTENDED 6'h13
`define LIU_FUNC_UNALIGNED_DOUBLE 6'h05
`define LIU_OPC_WORD 6'h23
`define LIU_OPC_FP_WORD 6'h31
`define LIU_ZERO_FIELD 5'h00

// ==========================================================
// Reset values and address constants
`define LIU_LINK_RST 1'b0
`define LIU_HI_WORD_XOR 3'h4

`endif

// [hdl/liu_pkg.sv]
// Types shared by the load instruction unit and its neighbours
package liu_pkg;

  // ==========================================================
  // Decoded operation
  typedef enum logic [2:0] {
    LIU_OP_ILLEGAL = 3'h0,
    LIU_OP_SIGNED_HALF = 3'h1,
    LIU_OP_UNSIGNED_HALF = 3'h2,
    LIU_OP_LINKED_WORD = 3'h3,
    LIU_OP_UPPER_IMM = 3'h4,
    LIU_OP_UNALIGNED_DOUBLE = 3'h5,
    LIU_OP_WORD = 3'h6,
    LIU_OP_FP_WORD = 3'h7
  } liu_op_e;

  // ==========================================================
  // Exception codes reported to the exception logic
  typedef enum logic [2:0] {
    LIU_EXC_NONE = 3'h0,
    LIU_EXC_ADDR_ERROR = 3'h1,
    LIU_EXC_TLB_REFILL = 3'h2,
    LIU_EXC_TLB_INVALID = 3'h3,
    LIU_EXC_BUS_ERROR = 3'h4,
    LIU_EXC_WATCH = 3'h5,
    LIU_EXC_RSVD_INSTR = 3'h6,
    LIU_EXC_COP_UNUSABLE = 3'h7
  } liu_exc_e;

  // ==========================================================
  // Memory access size
  typedef enum logic [1:0] {
    LIU_SIZE_HALF = 2'h1,
    LIU_SIZE_WORD = 2'h2
  } liu_size_e;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    LIU_ST_IDLE = 3'b001,
    LIU_ST_MEM_LO = 3'b010,
    LIU_ST_MEM_HI = 3'b100
  } liu_state_e;

  // ==========================================================
  // Faults returned with a memory answer
  typedef struct packed {
    logic tlb_refill;
    logic tlb_invalid;
    logic bus_err;
    logic watch;
  } liu_fault_s;

endpackage

// [hdl/liu_load_unit.sv]
// Load instruction unit: decode, effective address, alignment, lanes, write-back
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "liu_regs.svh"

// ==========================================================
// Behaviour
// RULE1 - Address is sign-extended offset plus base
// RULE2 - Unsigned halfword load zero-extends into GPR
// RULE3 - Odd halfword address: address error, no access
// RULE4 - Endian XOR on address bit, lane select
// RULE5 - Signed halfword reports translation, bus, watch faults
// RULE6 - Linked load fetches word, sets link flag
// RULE7 - One atomic sequence; new link replaces old
// RULE8 - Linked load never disturbs other processors
// RULE9 - Linked load checks word alignment, reserved instruction
// RULE10 - Software links only synchronizable locations
// RULE11 - Upper immediate shifted sixteen, no exception
// RULE12 - Indexed double address is base plus index
// RULE13 - Indexed double clears low bits, never misaligned
// RULE14 - Low word first, high at XOR four
// RULE15 - Sixteen register FP mode gives undefined result
// RULE16 - Indexed double raises only its listed exceptions
// RULE17 - Word load sign-extends to GPR width
// RULE18 - Word load checks two low address bits
// RULE19 - FP word load fills low word only
// RULE20 - FP word load checks word alignment
// RULE21 - Exception blocks register and link flag update
module liu_load_unit #(
  parameter int GW = 32
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input wire logic [31:0] instr_i,
  input wire logic [GW-1:0] base_i,
  input wire logic [GW-1:0] index_i,
  input wire logic reverse_endian_state_i,
  input wire logic big_endian_state_i,
  input wire logic cop1_usable_i,
  input wire logic fpu_sixteen_reg_mode_i,
  input wire logic link_enable_i,
  input wire logic link_clear_i,
  output logic mem_req_o,
  output logic [GW-1:0] mem_addr_o,
  output liu_pkg::liu_size_e mem_size_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire liu_pkg::liu_fault_s mem_fault_i,
  output logic done_o,
  output logic exc_valid_o,
  output liu_pkg::liu_exc_e exc_code_o,
  output logic [GW-1:0] exc_vaddr_o,
  output logic gpr_we_o,
  output logic [4:0] gpr_waddr_o,
  output logic [GW-1:0] gpr_wdata_o,
  output logic fpr_we_o,
  output logic fpr_hi_we_o,
  output logic [4:0] fpr_waddr_o,
  output logic [63:0] fpr_wdata_o,
  output logic link_flag_o
);

  // ==========================================================
  // Decode
  liu_pkg::liu_state_e state;
  liu_pkg::liu_op_e op;
  liu_pkg::liu_op_e op_q;
  liu_pkg::liu_exc_e early_exc;
  liu_pkg::liu_exc_e mem_exc;
  logic [5:0] opc;
  logic [5:0] func;
  logic accept;
  logic [GW-1:0] off_ext;
  logic [GW-1:0] ea_mem;
  logic [GW-1:0] ea_idx;
  logic [GW-1:0] ea_dbl;
  logic [GW-1:0] start_addr;
  logic [GW-1:0] vaddr_q;
  logic [4:0] dest_q;
  logic [1:0] lane_q;
  logic [31:0] lo_word_q;
  logic [15:0] half;
  logic [GW-1:0] upper_imm;

  assign opc = instr_i[`LIU_OPC_LSB +: 6];
  assign func = instr_i[`LIU_FUNC_LSB +: 6];
  assign issue_ready_o = (state == liu_pkg::LIU_ST_IDLE);
  assign accept = issue_valid_i && issue_ready_o;

  always_comb
  begin
    op = liu_pkg::LIU_OP_ILLEGAL;
    unique case (opc)
      `LIU_OPC_SIGNED_HALF: op = liu_pkg::LIU_OP_SIGNED_HALF;
      `LIU_OPC_UNSIGNED_HALF: op = liu_pkg::LIU_OP_UNSIGNED_HALF;
      `LIU_OPC_LINKED_WORD: op = liu_pkg::LIU_OP_LINKED_WORD;
      `LIU_OPC_WORD: op = liu_pkg::LIU_OP_WORD;
      `LIU_OPC_FP_WORD: op = liu_pkg::LIU_OP_FP_WORD;
      `LIU_OPC_UPPER_IMM:
        if (instr_i[`LIU_RS_LSB +: 5] == `LIU_ZERO_FIELD)
          op = liu_pkg::LIU_OP_UPPER_IMM;
      `LIU_OPC_FP_EXTENDED:
        if (func == `LIU_FUNC_UNALIGNED_DOUBLE
            && instr_i[`LIU_RD_LSB +: 5] == `LIU_ZERO_FIELD)
          op = liu_pkg::LIU_OP_UNALIGNED_DOUBLE; // RULE12
      default: op = liu_pkg::LIU_OP_ILLEGAL;
    endcase
  end

  // ==========================================================
  // Effective address
  assign off_ext = GW'($signed(instr_i[`LIU_IMM_LSB +: 16]));
  assign ea_mem = base_i + off_ext; // RULE1
  assign ea_idx = base_i + index_i; // RULE12
  assign ea_dbl = {ea_idx[GW-1:3], 3'h0}; // RULE13
  assign upper_imm = GW'($signed({instr_i[`LIU_IMM_LSB +: 16], 16'h0000})); // RULE11

  // Translation maps page bits only, so endian flips on low bits are applied here
  always_comb
  begin
    start_addr = ea_mem;
    if (op == liu_pkg::LIU_OP_UNALIGNED_DOUBLE)
      start_addr = ea_dbl ^ GW'({big_endian_state_i ^ reverse_endian_state_i, 2'h0});
    else if (op == liu_pkg::LIU_OP_SIGNED_HALF || op == liu_pkg::LIU_OP_UNSIGNED_HALF)
      start_addr = ea_mem ^ GW'({reverse_endian_state_i, 1'b0}); // RULE4
  end

  // Checks made before any memory access is started
  always_comb
  begin
    early_exc = liu_pkg::LIU_EXC_NONE;
    unique case (op)
      liu_pkg::LIU_OP_SIGNED_HALF,
      liu_pkg::LIU_OP_UNSIGNED_HALF:
        if (ea_mem[0])
          early_exc = liu_pkg::LIU_EXC_ADDR_ERROR; // RULE3
      liu_pkg::LIU_OP_LINKED_WORD:
        if (!link_enable_i)
          early_exc = liu_pkg::LIU_EXC_RSVD_INSTR; // RULE9
        else if (ea_mem[1:0] != 2'h0)
          early_exc = liu_pkg::LIU_EXC_ADDR_ERROR; // RULE9
      liu_pkg::LIU_OP_WORD:
        if (ea_mem[1:0] != 2'h0)
          early_exc = liu_pkg::LIU_EXC_ADDR_ERROR; // RULE18
      liu_pkg::LIU_OP_FP_WORD:
        if (!cop1_usable_i)
          early_exc = liu_pkg::LIU_EXC_COP_UNUSABLE;
        else if (ea_mem[1:0] != 2'h0)
          early_exc = liu_pkg::LIU_EXC_ADDR_ERROR; // RULE20
      liu_pkg::LIU_OP_UNALIGNED_DOUBLE:
        // Sixteen-register mode is not checked; the loaded value is undefined there
        if (!cop1_usable_i)
          early_exc = liu_pkg::LIU_EXC_COP_UNUSABLE; // RULE13 RULE15 RULE16
      liu_pkg::LIU_OP_UPPER_IMM:
        early_exc = liu_pkg::LIU_EXC_NONE; // RULE11
      liu_pkg::LIU_OP_ILLEGAL:
        early_exc = liu_pkg::LIU_EXC_RSVD_INSTR;
    endcase
  end

  // Faults from the memory side; bus error only where the load lists it
  always_comb
  begin
    mem_exc = liu_pkg::LIU_EXC_NONE;
    if (mem_fault_i.tlb_refill)
      mem_exc = liu_pkg::LIU_EXC_TLB_REFILL; // RULE5
    else if (mem_fault_i.tlb_invalid)
      mem_exc = liu_pkg::LIU_EXC_TLB_INVALID; // RULE5
    else if (mem_fault_i.watch)
      mem_exc = liu_pkg::LIU_EXC_WATCH; // RULE5
    else if (mem_fault_i.bus_err
             && (op_q == liu_pkg::LIU_OP_SIGNED_HALF || op_q == liu_pkg::LIU_OP_WORD))
      mem_exc = liu_pkg::LIU_EXC_BUS_ERROR; // RULE5 RULE16
  end

  // Lane is 0 or 2 only, since halfword addresses are even
  assign half = lane_q[1] ? mem_rdata_i[31:16] : mem_rdata_i[15:0]; // RULE4

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state <= liu_pkg::LIU_ST_IDLE;
    else
    begin
      unique case (state)
        liu_pkg::LIU_ST_IDLE:
          if (accept && early_exc == liu_pkg::LIU_EXC_NONE && op != liu_pkg::LIU_OP_UPPER_IMM)
            state <= liu_pkg::LIU_ST_MEM_LO; // RULE3
        liu_pkg::LIU_ST_MEM_LO:
          if (mem_ack_i)
          begin
            if (mem_exc == liu_pkg::LIU_EXC_NONE && op_q == liu_pkg::LIU_OP_UNALIGNED_DOUBLE)
              state <= liu_pkg::LIU_ST_MEM_HI; // RULE14
            else
              state <= liu_pkg::LIU_ST_IDLE;
          end
        liu_pkg::LIU_ST_MEM_HI:
          if (mem_ack_i)
            state <= liu_pkg::LIU_ST_IDLE;
      endcase
    end
  end

  // Operation context held for the length of the access
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      op_q <= liu_pkg::LIU_OP_ILLEGAL;
      dest_q <= 5'h00;
      lane_q <= 2'h0;
      vaddr_q <= '0;
    end
    else if (accept)
    begin
      op_q <= op;
      dest_q <= (op == liu_pkg::LIU_OP_UNALIGNED_DOUBLE) ?
                instr_i[`LIU_FD_LSB +: 5] : instr_i[`LIU_RT_LSB +: 5];
      lane_q <= ea_mem[1:0] ^ {big_endian_state_i, 1'b0}; // RULE4
      vaddr_q <= (op == liu_pkg::LIU_OP_UNALIGNED_DOUBLE) ? ea_dbl : ea_mem;
    end
  end

  // ==========================================================
  // Memory request
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mem_req_o <= 1'b0;
      mem_addr_o <= '0;
      mem_size_o <= liu_pkg::LIU_SIZE_WORD;
    end
    else if (accept)
    begin
      mem_req_o <= (early_exc == liu_pkg::LIU_EXC_NONE) && (op != liu_pkg::LIU_OP_UPPER_IMM);
      mem_addr_o <= start_addr; // RULE1
      mem_size_o <= (op == liu_pkg::LIU_OP_SIGNED_HALF || op == liu_pkg::LIU_OP_UNSIGNED_HALF) ?
                    liu_pkg::LIU_SIZE_HALF : liu_pkg::LIU_SIZE_WORD;
    end
    else if (mem_ack_i && state == liu_pkg::LIU_ST_MEM_LO
             && op_q == liu_pkg::LIU_OP_UNALIGNED_DOUBLE && mem_exc == liu_pkg::LIU_EXC_NONE)
      mem_addr_o <= mem_addr_o ^ GW'(`LIU_HI_WORD_XOR); // RULE14
    else if (mem_ack_i)
      mem_req_o <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      lo_word_q <= 32'h00000000;
    else if (mem_ack_i && state == liu_pkg::LIU_ST_MEM_LO)
      lo_word_q <= mem_rdata_i; // RULE14
  end

  // ==========================================================
  // Write-back and exception report, one-cycle pulses
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      done_o <= 1'b0;
      exc_valid_o <= 1'b0;
      exc_code_o <= liu_pkg::LIU_EXC_NONE;
      exc_vaddr_o <= '0;
      gpr_we_o <= 1'b0;
      gpr_waddr_o <= 5'h00;
      gpr_wdata_o <= '0;
      fpr_we_o <= 1'b0;
      fpr_hi_we_o <= 1'b0;
      fpr_waddr_o <= 5'h00;
      fpr_wdata_o <= 64'h0000000000000000;
    end
    else
    begin
      done_o <= 1'b0;
      exc_valid_o <= 1'b0;
      gpr_we_o <= 1'b0;
      fpr_we_o <= 1'b0;
      fpr_hi_we_o <= 1'b0;
      if (accept && early_exc != liu_pkg::LIU_EXC_NONE)
      begin
        done_o <= 1'b1;
        exc_valid_o <= 1'b1; // RULE21
        exc_code_o <= early_exc;
        exc_vaddr_o <= (op == liu_pkg::LIU_OP_UNALIGNED_DOUBLE) ? ea_dbl : ea_mem;
      end
      else if (accept && op == liu_pkg::LIU_OP_UPPER_IMM)
      begin
        done_o <= 1'b1;
        gpr_we_o <= 1'b1;
        gpr_waddr_o <= instr_i[`LIU_RT_LSB +: 5];
        gpr_wdata_o <= upper_imm; // RULE11
      end
      else if (mem_ack_i && state != liu_pkg::LIU_ST_IDLE && mem_exc != liu_pkg::LIU_EXC_NONE)
      begin
        done_o <= 1'b1;
        exc_valid_o <= 1'b1; // RULE21
        exc_code_o <= mem_exc;
        exc_vaddr_o <= vaddr_q;
      end
      else if (mem_ack_i && state == liu_pkg::LIU_ST_MEM_HI)
      begin
        done_o <= 1'b1;
        fpr_we_o <= 1'b1;
        fpr_hi_we_o <= 1'b1;
        fpr_waddr_o <= dest_q;
        fpr_wdata_o <= {mem_rdata_i, lo_word_q}; // RULE14
      end
      else if (mem_ack_i && state == liu_pkg::LIU_ST_MEM_LO
               && op_q != liu_pkg::LIU_OP_UNALIGNED_DOUBLE)
      begin
        done_o <= 1'b1;
        if (op_q == liu_pkg::LIU_OP_FP_WORD)
        begin
          // Upper half left untouched; its content is undefined after this load
          fpr_we_o <= 1'b1; // RULE19
          fpr_waddr_o <= dest_q;
          fpr_wdata_o <= {32'h00000000, mem_rdata_i}; // RULE19
        end
        else
        begin
          gpr_we_o <= 1'b1;
          gpr_waddr_o <= dest_q;
          unique case (op_q)
            liu_pkg::LIU_OP_SIGNED_HALF: gpr_wdata_o <= GW'($signed(half));
            liu_pkg::LIU_OP_UNSIGNED_HALF: gpr_wdata_o <= GW'(half); // RULE2
            default: gpr_wdata_o <= GW'($signed(mem_rdata_i)); // RULE6 RULE17
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Link flag
  // Only a local flag; no snoop or invalidate goes out, so remote stores are unaffected
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      link_flag_o <= `LIU_LINK_RST;
    else if (mem_ack_i && state == liu_pkg::LIU_ST_MEM_LO
             && op_q == liu_pkg::LIU_OP_LINKED_WORD && mem_exc == liu_pkg::LIU_EXC_NONE)
      link_flag_o <= 1'b1; // RULE6 RULE7 RULE8 RULE21
    else if (link_clear_i)
      link_flag_o <= 1'b0;
  end

  // ==========================================================
  // Assertions
  a_ea_request: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE1
    accept && op == liu_pkg::LIU_OP_WORD && early_exc == liu_pkg::LIU_EXC_NONE
    |=> mem_req_o && mem_addr_o == $past(base_i) + GW'($signed($past(instr_i[15:0]))))
    else $error("word load address wrong");

  a_half_align: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE3
    accept && (op == liu_pkg::LIU_OP_SIGNED_HALF || op == liu_pkg::LIU_OP_UNSIGNED_HALF)
    && ea_mem[0]
    |=> exc_valid_o && exc_code_o == liu_pkg::LIU_EXC_ADDR_ERROR && !mem_req_o)
    else $error("odd halfword address not refused");

  a_word_align: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE18
    accept && op == liu_pkg::LIU_OP_WORD && ea_mem[1:0] != 2'h0
    |=> exc_valid_o && exc_code_o == liu_pkg::LIU_EXC_ADDR_ERROR && !gpr_we_o)
    else $error("misaligned word not refused");

  a_upper_imm: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE11
    accept && op == liu_pkg::LIU_OP_UPPER_IMM
    |=> gpr_we_o && !exc_valid_o && gpr_wdata_o[15:0] == 16'h0000
    && gpr_wdata_o[31:16] == $past(instr_i[15:0]))
    else $error("upper immediate result wrong");

  a_link_set: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE6
    mem_ack_i && state == liu_pkg::LIU_ST_MEM_LO && op_q == liu_pkg::LIU_OP_LINKED_WORD
    && mem_exc == liu_pkg::LIU_EXC_NONE
    |=> link_flag_o && gpr_we_o && gpr_wdata_o[31:0] == $past(mem_rdata_i))
    else $error("linked load did not set link flag");

  a_exc_no_write: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE21
    exc_valid_o |-> !gpr_we_o && !fpr_we_o
    && (link_flag_o == $past(link_flag_o) || $past(link_clear_i)))
    else $error("state updated on exception");

  a_hi_word_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE14
    mem_ack_i && state == liu_pkg::LIU_ST_MEM_LO
    && op_q == liu_pkg::LIU_OP_UNALIGNED_DOUBLE && mem_exc == liu_pkg::LIU_EXC_NONE
    |=> state == liu_pkg::LIU_ST_MEM_HI && mem_req_o
    && mem_addr_o == ($past(mem_addr_o) ^ GW'(`LIU_HI_WORD_XOR)))
    else $error("high word address wrong");

  a_dbl_no_align: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE13
    accept && op == liu_pkg::LIU_OP_UNALIGNED_DOUBLE && cop1_usable_i
    |=> mem_req_o && mem_addr_o[1:0] == 2'h0 && !exc_valid_o)
    else $error("indexed double misaligned or refused");

  a_unsigned_ext: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE2
    mem_ack_i && state == liu_pkg::LIU_ST_MEM_LO && op_q == liu_pkg::LIU_OP_UNSIGNED_HALF
    && mem_exc == liu_pkg::LIU_EXC_NONE
    |=> gpr_we_o && gpr_wdata_o[GW-1:16] == '0)
    else $error("unsigned halfword not zero-extended");

endmodule // liu_load_unit

// [verification/liu_mem_model.sv]
// Memory side model: answers loads after a chosen latency with address-derived data
`timescale 1ns/1ps

// ==========================================================
// Memory answer model
module liu_mem_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [3:0] lat_i,
  input wire liu_pkg::liu_fault_s fault_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o,
  output liu_pkg::liu_fault_s mem_fault_o
);
  logic [3:0] wait_cnt;

  // Each word of a transfer is answered on its own, so the second word waits again
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wait_cnt <= 4'h0;
      mem_ack_o <= 1'h0;
      mem_rdata_o <= 32'h0;
      mem_fault_o <= '0;
    end
    else if (mem_req_i && !mem_ack_o && wait_cnt >= lat_i)
    begin
      mem_ack_o <= 1'h1;
      mem_rdata_o <= {mem_addr_i[15:0] ^ 16'hF0A5, mem_addr_i[15:2], 2'h0};
      mem_fault_o <= fault_i;
      wait_cnt <= 4'h0;
    end
    else
    begin
      // Outside an answer the data lines carry no usable value
      mem_ack_o <= 1'h0;
      mem_rdata_o <= ~mem_rdata_o;
      mem_fault_o <= ~mem_fault_o;
      if (mem_req_i && !mem_ack_o)
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // liu_mem_model

// [verification/tb_top.sv]
// Self-checking bench for the load instruction unit
`timescale 1ns/1ps

module tb_top;
  typedef struct {
    logic [31:0] instr;
    logic [31:0] base;
    logic [31:0] idx;
    logic big;
    logic rev;
    logic [3:0] fault;
    logic [2:0] exc;
    logic [3:0] lat;
  } liu_tb_row_s;

  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic issue_valid = 1'h0;
  logic [31:0] instr = 32'h0;
  logic [31:0] base = 32'h0;
  logic [31:0] index = 32'h0;
  logic big = 1'h0;
  logic rev = 1'h0;
  logic cop1 = 1'h1;
  logic link_en = 1'h1;
  logic link_clr = 1'h0;
  logic [3:0] fault = 4'h0;
  logic [3:0] lat = 4'h0;
  logic issue_ready, mem_req, mem_ack, done, exc_valid, gpr_we, fpr_we, fpr_hi_we, link_flag;
  logic [31:0] mem_addr, mem_rdata, exc_vaddr, gpr_wdata;
  logic [4:0] gpr_waddr, fpr_waddr;
  logic [63:0] fpr_wdata;
  liu_pkg::liu_size_e mem_size;
  liu_pkg::liu_fault_s mem_fault;
  liu_pkg::liu_exc_e exc_code;
  logic [33:0] addr_q[$];
  liu_tb_row_s rows[$];
  logic link_exp = 1'h0;
  int compares = 0;
  int miscompares = 0;
  int tno = 0;

  liu_load_unit liu_load_unit_inst (.clk_i(clk), .sys_rst_i(sys_rst),
    .issue_valid_i(issue_valid), .issue_ready_o(issue_ready), .instr_i(instr),
    .base_i(base), .index_i(index), .reverse_endian_state_i(rev),
    .big_endian_state_i(big), .cop1_usable_i(cop1), .fpu_sixteen_reg_mode_i(1'h0),
    .link_enable_i(link_en), .link_clear_i(link_clr), .mem_req_o(mem_req),
    .mem_addr_o(mem_addr), .mem_size_o(mem_size), .mem_ack_i(mem_ack),
    .mem_rdata_i(mem_rdata), .mem_fault_i(mem_fault), .done_o(done),
    .exc_valid_o(exc_valid), .exc_code_o(exc_code), .exc_vaddr_o(exc_vaddr),
    .gpr_we_o(gpr_we), .gpr_waddr_o(gpr_waddr), .gpr_wdata_o(gpr_wdata),
    .fpr_we_o(fpr_we), .fpr_hi_we_o(fpr_hi_we), .fpr_waddr_o(fpr_waddr),
    .fpr_wdata_o(fpr_wdata), .link_flag_o(link_flag));

  liu_mem_model liu_mem_model_inst (.clk_i(clk), .sys_rst_i(sys_rst), .mem_req_i(mem_req),
    .mem_addr_i(mem_addr), .lat_i(lat), .fault_i(fault), .mem_ack_o(mem_ack),
    .mem_rdata_o(mem_rdata), .mem_fault_o(mem_fault));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // Record every answered access with its size
  always @(negedge clk)
    if (mem_req === 1'h1 && mem_ack === 1'h1)
      addr_q.push_back({mem_size, mem_addr});

  // ==========================================================
  // Helpers
  function automatic logic [31:0] mword(input logic [31:0] a);
    return {a[15:0] ^ 16'hF0A5, a[15:2], 2'h0};
  endfunction

  function automatic liu_tb_row_s rw(input logic [5:0] op, input logic [4:0] rs,
    input logic [15:0] imm, input logic [31:0] b, input logic [31:0] ix, input logic bg,
    input logic rv, input logic [3:0] f, input logic [2:0] e, input logic [3:0] l);
    return '{{op, rs, 5'h07, imm}, b, ix, bg, rv, f, e, l};
  endfunction

  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_val({63'h0, got}, {63'h0, exp});
  endtask

  task automatic close_out();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic run(input liu_tb_row_s r);
    logic [5:0] op;
    logic [31:0] ea;
    logic [31:0] a0;
    logic [31:0] w;
    logic [15:0] h;
    logic [1:0] ln;
    logic ok;
    logic half;
    int n;
    op = r.instr[31:26];
    ea = (op == 6'h13) ? r.base + r.idx : r.base + {{16{r.instr[15]}}, r.instr[15:0]};
    half = (op == 6'h21 || op == 6'h25);
    a0 = half ? ea ^ {30'h0, r.rev, 1'h0} : ea;
    if (op == 6'h13)
      a0 = {ea[31:3], 3'h0} ^ {29'h0, r.big ^ r.rev, 2'h0};
    ok = (r.exc == 3'h0);
    n = (r.exc inside {3'h1, 3'h6, 3'h7} || op == 6'h0F) ? 0 : ((op == 6'h13 && ok) ? 2 : 1);
    w = mword(a0);
    ln = ea[1:0] ^ {r.big, 1'h0};
    h = ln[1] ? w[31:16] : w[15:0];
    addr_q.delete();
    @(posedge clk);
    issue_valid <= 1'h1;
    instr <= r.instr;
    base <= r.base;
    index <= r.idx;
    big <= r.big;
    rev <= r.rev;
    fault <= r.fault;
    lat <= r.lat;
    @(posedge clk);
    issue_valid <= 1'h0;
    for (int i = 0; i < 40 && done !== 1'h1; i++)
      @(negedge clk);
    cmp_flag(done, 1'h1);
    cmp_flag(exc_valid, !ok);
    if (!ok)
      cmp_val(64'(exc_code), 64'(r.exc));
    if (r.exc == 3'h1)
      cmp_val(64'(exc_vaddr), 64'(ea));
    cmp_val(64'(addr_q.size()), 64'(n));
    if (addr_q.size() > 0)
      cmp_val(64'(addr_q[0]), 64'({half ? 2'h1 : 2'h2, a0}));
    if (addr_q.size() > 1)
      cmp_val(64'(addr_q[1]), 64'({2'h2, a0 ^ 32'h4}));
    cmp_flag(gpr_we, ok && op inside {6'h21, 6'h25, 6'h23, 6'h30, 6'h0F});
    cmp_flag(fpr_we, ok && op inside {6'h13, 6'h31});
    if (ok && gpr_we === 1'h1)
      cmp_val(64'(gpr_waddr), 64'h7);
    if (ok && op == 6'h21)
      cmp_val(64'(gpr_wdata), 64'({{16{h[15]}}, h}));
    if (ok && op == 6'h25)
      cmp_val(64'(gpr_wdata), 64'({16'h0, h}));
    if (ok && (op == 6'h23 || op == 6'h30))
      cmp_val(64'(gpr_wdata), 64'(w));
    if (ok && op == 6'h0F)
      cmp_val(64'(gpr_wdata), 64'({r.instr[15:0], 16'h0}));
    if (ok && op == 6'h13)
      cmp_val(fpr_wdata, {mword(a0 ^ 32'h4), w});
    if (ok && op == 6'h31)
      cmp_val(64'(fpr_wdata[31:0]), 64'(w));
    if (ok && op inside {6'h13, 6'h31})
      cmp_val(64'({fpr_hi_we, fpr_waddr}), 64'({op == 6'h13, op == 6'h13 ? 5'h03 : 5'h07}));
    if (ok && op == 6'h30)
      link_exp = 1'h1;
    cmp_flag(link_flag, link_exp);
    $display("test %0d done", tno);
    tno++;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (3) @(negedge clk);
    cmp_val(64'({issue_ready, link_flag, mem_req, done, mem_size}), 64'h22);
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    rows.push_back(rw(6'h21, 5'h01, 16'h0002, 32'h1000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h0));
    rows.push_back(rw(6'h21, 5'h01, 16'hFFFE, 32'h1000, 32'h0, 1'h1, 1'h1, 4'h0, 3'h0, 4'h2));
    rows.push_back(rw(6'h21, 5'h01, 16'h0001, 32'h1000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h1, 4'h0));
    rows.push_back(rw(6'h25, 5'h01, 16'h0002, 32'h2000, 32'h0, 1'h1, 1'h0, 4'h0, 3'h0, 4'h1));
    rows.push_back(rw(6'h25, 5'h01, 16'h0000, 32'h2000, 32'h0, 1'h0, 1'h1, 4'h0, 3'h0, 4'h0));
    rows.push_back(rw(6'h25, 5'h01, 16'h0003, 32'h2000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h1, 4'h0));
    rows.push_back(rw(6'h25, 5'h01, 16'h0000, 32'h2000, 32'h0, 1'h0, 1'h0, 4'h2, 3'h0, 4'h0));
    rows.push_back(rw(6'h21, 5'h01, 16'h0000, 32'h1000, 32'h0, 1'h0, 1'h0, 4'h2, 3'h4, 4'h0));
    rows.push_back(rw(6'h21, 5'h01, 16'h0000, 32'h1000, 32'h0, 1'h0, 1'h0, 4'h8, 3'h2, 4'h0));
    rows.push_back(rw(6'h21, 5'h01, 16'h0000, 32'h1000, 32'h0, 1'h0, 1'h0, 4'h4, 3'h3, 4'h0));
    rows.push_back(rw(6'h21, 5'h01, 16'h0000, 32'h1000, 32'h0, 1'h0, 1'h0, 4'h1, 3'h5, 4'h0));
    rows.push_back(rw(6'h23, 5'h01, 16'h0004, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h3));
    rows.push_back(rw(6'h23, 5'h01, 16'h0002, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h1, 4'h0));
    rows.push_back(rw(6'h23, 5'h01, 16'h0001, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h1, 4'h0));
    rows.push_back(rw(6'h23, 5'h01, 16'h0000, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h2, 3'h4, 4'h0));
    rows.push_back(rw(6'h30, 5'h01, 16'h0008, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h0));
    rows.push_back(rw(6'h0F, 5'h00, 16'h8001, 32'h0, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h0));
    rows.push_back(rw(6'h0F, 5'h03, 16'h1234, 32'h0, 32'h0, 1'h0, 1'h0, 4'h0, 3'h6, 4'h0));
    rows.push_back(rw(6'h13, 5'h01, 16'h00C5, 32'h4003, 32'h4, 1'h0, 1'h1, 4'h0, 3'h0, 4'h1));
    rows.push_back(rw(6'h13, 5'h01, 16'h00C4, 32'h4000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h6, 4'h0));
    rows.push_back(rw(6'h13, 5'h01, 16'h08C5, 32'h4000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h6, 4'h0));
    rows.push_back(rw(6'h13, 5'h01, 16'h00C5, 32'h4000, 32'h1, 1'h1, 1'h0, 4'h2, 3'h0, 4'h0));
    rows.push_back(rw(6'h13, 5'h01, 16'h00C5, 32'h4000, 32'h0, 1'h0, 1'h0, 4'h1, 3'h5, 4'h0));
    rows.push_back(rw(6'h31, 5'h01, 16'h0010, 32'h5000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h0));
    rows.push_back(rw(6'h31, 5'h01, 16'h0002, 32'h5000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h1, 4'h0));
    foreach (rows[i])
      run(rows[i]);
    // Linked loads only touch synchronizable words here
    @(posedge clk);
    link_clr <= 1'h1;
    @(posedge clk);
    link_clr <= 1'h0;
    @(negedge clk);
    link_exp = 1'h0;
    cmp_flag(link_flag, 1'h0);
    run(rw(6'h30, 5'h01, 16'h0002, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h1, 4'h0));
    link_en <= 1'h0;
    run(rw(6'h30, 5'h01, 16'h0000, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h6, 4'h0));
    link_en <= 1'h1;
    run(rw(6'h30, 5'h01, 16'h0004, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h1));
    run(rw(6'h30, 5'h01, 16'h000C, 32'h3000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h0));
    cop1 <= 1'h0;
    run(rw(6'h31, 5'h01, 16'h0000, 32'h5000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h7, 4'h0));
    run(rw(6'h13, 5'h01, 16'h00C5, 32'h4000, 32'h0, 1'h0, 1'h0, 4'h0, 3'h7, 4'h0));
    cop1 <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h1;
    @(negedge clk);
    link_exp = 1'h0;
    cmp_flag(link_flag, 1'h0);
    @(posedge clk);
    sys_rst <= 1'h0;
    run(rw(6'h0F, 5'h00, 16'h7FFF, 32'h0, 32'h0, 1'h0, 1'h0, 4'h0, 3'h0, 4'h0));
    close_out();
  end

  // Thirty-two short instructions need well under two thousand cycles
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule // tb_top
